// ==== design/ppmc_top.v ====
// How it works
// - Mode register accepts values zero to fifteen.
// - Pins evaluated only on instruction boundary strobe.
// - Mode 0 stops polling, erases both configs.
// - Mode 1 stops polling, keeps configuration.
// - Mode 2: outputs and wait, no switch.
// - Mode 3: slot switch only.
// - Mode 4: outputs, wait and switch.
// - Modes 5-7 erase configs, keep mode.
// - Modes 8-15 mirror 0-7 with latched outputs.
// - Outputs follow, latch once, or stay still.
// - Switch drops mode 3 to 1, 4 to 2.
// - Clear modes keep previous mode in force.
// - Clear modes leave driven output levels alone.
// - New output joins polling at once.
// - Wait releases only in modes 2, 4, 10 or 12.
// - Output pins update the cycle after boundary_done_o.
// - Trigger status kept at scratch 128-131; 132-135 read zero.
// - Any triggered input drives every output enabled in out_en_r.
// - Non-latched outputs active only while condition.
// - Status bit one when its input triggered.
`timescale 1ns/1ps
`include "ppmc_defs.vh"
module ppmc_top
(
	input wire sys_clk_i,
	input wire resetn_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire hsel_i,
	input wire hready_i,
	input wire [31:0] hwdata_i,
	output reg [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	input wire [`PPMC_NPINS-1:0] pin_in_i,
	output reg [`PPMC_NPINS-1:0] pin_out_o,
	output reg [`PPMC_NPINS-1:0] pin_oe_n_o,
	input wire boundary_i,
	input wire wait_active_i,
	output reg boundary_done_o,
	output reg wait_release_o,
	output reg slot_switch_o,
	output reg [`PPMC_SLOT_W-1:0] slot_num_o,
	input wire [7:0] scratch_addr_i,
	output reg [7:0] scratch_data_o
);
	localparam NP = `PPMC_NPINS;
	reg [`PPMC_MODE_W-1:0] mode_r;
	reg [NP-1:0] in_en_r;
	reg [NP-1:0] in_tgt_r;
	reg [NP-1:0] out_en_r;
	reg [NP-1:0] out_act_r;
	reg [NP-1:0] trig_r;
	reg [`PPMC_SLOT_W-1:0] slot_r;
	reg [NP-1:0] pin_s1_r;
	reg [NP-1:0] pin_s2_r;
	reg ph_wr_r;
	reg [11:0] ph_addr_r;
	reg [NP-1:0] drv_lvl_r;
	wire [NP-1:0] hit;
	wire cond;
	wire [2:0] base;
	wire latched;
	wire out_on;
	wire run_on;
	wire poll_on;
	wire take;
	wire wr_mode;
	wire [2:0] wbase;
	wire [3:0] wsel;
	wire [3:0] rsel;
	wire [NP-1:0] lvl_nxt;
	wire [NP-1:0] oe_n_nxt;
	localparam SEL_MODE = 4'h0;
	localparam SEL_IN_EN = 4'h1;
	localparam SEL_IN_TGT = 4'h2;
	localparam SEL_OUT_EN = 4'h3;
	localparam SEL_OUT_ACT = 4'h4;
	localparam SEL_SLOT = 4'h5;
	localparam SEL_PINS = 4'h6;
	localparam SEL_STAT = 4'h7;
	localparam SEL_TRIG = 4'h8;
	localparam SEL_NONE = 4'hF;
	function is_clear;
		input [2:0] b;
		begin
			is_clear = (b == `PPMC_M_CLR_IN) || (b == `PPMC_M_CLR_OUT)
				|| (b == `PPMC_M_CLR_BOTH);
		end
	endfunction
	// Register index from a byte address
	function [3:0] addr_sel;
		input [11:0] a;
		begin
			if (a == `PPMC_A_MODE)
				addr_sel = SEL_MODE;
			else if (a == `PPMC_A_IN_EN)
				addr_sel = SEL_IN_EN;
			else if (a == `PPMC_A_IN_TGT)
				addr_sel = SEL_IN_TGT;
			else if (a == `PPMC_A_OUT_EN)
				addr_sel = SEL_OUT_EN;
			else if (a == `PPMC_A_OUT_ACT)
				addr_sel = SEL_OUT_ACT;
			else if (a == `PPMC_A_SLOT)
				addr_sel = SEL_SLOT;
			else if (a == `PPMC_A_PINS)
				addr_sel = SEL_PINS;
			else if (a == `PPMC_A_STAT)
				addr_sel = SEL_STAT;
			else if (a == `PPMC_A_TRIG)
				addr_sel = SEL_TRIG;
			else
				addr_sel = SEL_NONE;
		end
	endfunction
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign take = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);
	assign hit = in_en_r & ~(pin_s2_r ^ in_tgt_r);
	assign cond = |hit;
	assign base = mode_r[2:0];
	assign latched = mode_r[`PPMC_LATCH_BIT];
	assign out_on = (base == `PPMC_M_OUT) || (base == `PPMC_M_OUT_RUN);
	assign run_on = (base == `PPMC_M_RUN) || (base == `PPMC_M_OUT_RUN);
	assign poll_on = out_on || run_on;
	assign wsel = addr_sel(ph_addr_r);
	assign rsel = addr_sel(haddr_i[11:0]);
	assign wr_mode = ph_wr_r && (wsel == SEL_MODE);
	assign wbase = hwdata_i[2:0];
	// Pin synchroniser
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_s1_r <= {NP{1'b0}};
			pin_s2_r <= {NP{1'b0}};
		end
		else
		begin
			pin_s1_r <= pin_in_i;
			pin_s2_r <= pin_s1_r;
		end
	end
	// Bus address phase
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ph_wr_r <= 1'b0;
			ph_addr_r <= 12'h000;
		end
		else if (hready_i)
		begin
			ph_wr_r <= take && hwrite_i;
			ph_addr_r <= haddr_i[11:0];
		end
	end
	// Configuration, mode and polling step
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mode_r <= `PPMC_MODE_RST;
			in_en_r <= {NP{1'b0}};
			in_tgt_r <= {NP{1'b0}};
			out_en_r <= {NP{1'b0}};
			out_act_r <= {NP{1'b0}};
			slot_r <= 4'h0;
			trig_r <= {NP{1'b0}};
			drv_lvl_r <= {NP{1'b0}};
			boundary_done_o <= 1'b0;
			wait_release_o <= 1'b0;
			slot_switch_o <= 1'b0;
			slot_num_o <= 4'h0;
		end
		else
		begin
			boundary_done_o <= 1'b0;
			wait_release_o <= 1'b0;
			slot_switch_o <= 1'b0;
			if (boundary_i && poll_on)
			begin
				trig_r <= latched ? (trig_r | hit) : hit;
				if (out_on)
				begin
					// Output levels and the wait release register together in the same step
					if (latched)
					begin
						drv_lvl_r <= drv_lvl_r | ({NP{cond}} & out_en_r);
					end
					else
					begin
						// A cleared output keeps its last level
						drv_lvl_r <= (drv_lvl_r & ~out_en_r)
							| ({NP{cond}} & out_en_r);
					end
					wait_release_o <= wait_active_i && cond;
				end
				if (run_on && cond)
				begin
					slot_switch_o <= 1'b1;
					slot_num_o <= slot_r;
					mode_r <= {latched, (base == `PPMC_M_RUN) ? `PPMC_M_OFF_SAVE
						: `PPMC_M_OUT};
				end
			end
			if (boundary_i)
			begin
				boundary_done_o <= 1'b1;
			end
			if (ph_wr_r)
			begin
				if (wr_mode)
				begin
					if (!is_clear(wbase))
					begin
						mode_r <= hwdata_i[3:0];
					end
					if (wbase == `PPMC_M_OFF_CLR)
					begin
						in_en_r <= {NP{1'b0}};
						out_en_r <= {NP{1'b0}};
						trig_r <= {NP{1'b0}};
					end
					if (wbase == `PPMC_M_CLR_IN || wbase == `PPMC_M_CLR_BOTH)
					begin
						in_en_r <= {NP{1'b0}};
					end
					if (wbase == `PPMC_M_CLR_OUT || wbase == `PPMC_M_CLR_BOTH)
					begin
						out_en_r <= {NP{1'b0}};
					end
				end
				else if (wsel == SEL_IN_EN)
				begin
					in_en_r <= hwdata_i;
				end
				else if (wsel == SEL_IN_TGT)
				begin
					in_tgt_r <= hwdata_i;
				end
				else if (wsel == SEL_OUT_EN)
				begin
					out_en_r <= hwdata_i;
				end
				else if (wsel == SEL_OUT_ACT)
				begin
					out_act_r <= hwdata_i;
				end
				else if (wsel == SEL_SLOT)
				begin
					slot_r <= hwdata_i[3:0];
				end
			end
		end
	end
	// Pin drive: level moves only in the cycle after boundary_done_o, polling or not
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi = gi + 1)
		begin : g_pin
			// Active level when triggered, inverse otherwise
			assign lvl_nxt[gi] = drv_lvl_r[gi] ~^ out_act_r[gi];
			// Once defined, a pin keeps driving
			assign oe_n_nxt[gi] = pin_oe_n_o[gi] & ~out_en_r[gi];
		end
	endgenerate
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_out_o <= {NP{1'b0}};
			pin_oe_n_o <= {NP{1'b1}};
		end
		else
		begin
			if (boundary_done_o)
			begin
				pin_out_o <= lvl_nxt;
			end
			pin_oe_n_o <= oe_n_nxt;
		end
	end
	// Register read and scratch status
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hrdata_o <= 32'h0000_0000;
			scratch_data_o <= 8'h00;
		end
		else
		begin
			if (take && !hwrite_i)
			begin
				if (rsel == SEL_MODE)
				begin
					hrdata_o <= {28'h000_0000, mode_r};
				end
				else if (rsel == SEL_IN_EN)
				begin
					hrdata_o <= in_en_r;
				end
				else if (rsel == SEL_IN_TGT)
				begin
					hrdata_o <= in_tgt_r;
				end
				else if (rsel == SEL_OUT_EN)
				begin
					hrdata_o <= out_en_r;
				end
				else if (rsel == SEL_OUT_ACT)
				begin
					hrdata_o <= out_act_r;
				end
				else if (rsel == SEL_SLOT)
				begin
					hrdata_o <= {28'h000_0000, slot_r};
				end
				else if (rsel == SEL_PINS)
				begin
					hrdata_o <= pin_s2_r;
				end
				else if (rsel == SEL_STAT)
				begin
					hrdata_o <= {{30{1'b0}}, cond, poll_on};
				end
				else if (rsel == SEL_TRIG)
				begin
					hrdata_o <= trig_r;
				end
				else
				begin
					hrdata_o <= 32'h0000_0000;
				end
			end
			if (scratch_addr_i >= `PPMC_STAT_BASE && scratch_addr_i <= `PPMC_STAT_LAST)
			begin
				if (scratch_addr_i[2] == 1'b0)
					scratch_data_o <= trig_r[{scratch_addr_i[1:0], 3'b000} +: 8];
				else
					scratch_data_o <= 8'h00;
			end
			else
				scratch_data_o <= 8'h00;
		end
	end
endmodule // ppmc_top

// ==== common/ppmc_defs.vh ====
`ifndef PPMC_DEFS_VH
`define PPMC_DEFS_VH
`define PPMC_NPINS 32
`define PPMC_MODE_W 4
`define PPMC_MODE_RST 4'h0
`define PPMC_M_OFF_CLR 3'h0
`define PPMC_M_OFF_SAVE 3'h1
`define PPMC_M_OUT 3'h2
`define PPMC_M_RUN 3'h3
`define PPMC_M_OUT_RUN 3'h4
`define PPMC_M_CLR_IN 3'h5
`define PPMC_M_CLR_OUT 3'h6
`define PPMC_M_CLR_BOTH 3'h7
`define PPMC_LATCH_BIT 3
`define PPMC_STAT_BASE 8'h80
`define PPMC_STAT_LAST 8'h87
`define PPMC_SLOT_W 4
`define PPMC_A_BASE 12'h000
`define PPMC_A_MODE 12'h000
`define PPMC_A_IN_EN 12'h004
`define PPMC_A_IN_TGT 12'h008
`define PPMC_A_OUT_EN 12'h00C
`define PPMC_A_OUT_ACT 12'h010
`define PPMC_A_SLOT 12'h014
`define PPMC_A_PINS 12'h018
`define PPMC_A_STAT 12'h01C
`define PPMC_A_TRIG 12'h020
`endif

// ==== verif/ppmc_top_asserts.sv ====
`timescale 1ns/1ps
module ppmc_chk
(
	input wire sys_clk_i,
	input wire resetn_i,
	input wire boundary_i,
	input wire wait_active_i,
	input wire boundary_done_o,
	input wire wait_release_o,
	input wire slot_switch_o,
	input wire hreadyout_o,
	input wire hresp_o,
	input wire [31:0] pin_out_o,
	input wire [31:0] pin_oe_n_o
);
default clocking @(posedge sys_clk_i);
endclocking
default disable iff (!resetn_i);
sequence s_step;
	boundary_i ##1 boundary_done_o;
endsequence
AST_DONE: assert property (boundary_i |-> s_step) else $error("step not done");
AST_NODONE: assert property (!boundary_i |=> !boundary_done_o) else $error("stray done");
AST_REL: assert property (wait_release_o |-> boundary_done_o && $past(wait_active_i))
	else $error("bad release");
AST_SW: assert property (slot_switch_o |-> boundary_done_o) else $error("bad switch");
AST_ONCE: assert property (slot_switch_o |=> !slot_switch_o [*8]) else $error("again");
AST_PIN: assert property (!$stable(pin_out_o) |-> $past(boundary_i, 2)) else $error("pin");
AST_OE: assert property ((pin_oe_n_o & ~$past(pin_oe_n_o)) == 32'h0000_0000)
	else $error("drive lost");
AST_RDY: assert property (hreadyout_o && !hresp_o) else $error("bus stall");
endmodule // ppmc_chk
bind ppmc_top ppmc_chk ppmc_chk_i (.sys_clk_i, .resetn_i, .boundary_i, .wait_active_i,
	.boundary_done_o, .wait_release_o, .slot_switch_o, .hreadyout_o, .hresp_o,
	.pin_out_o, .pin_oe_n_o);

// ==== verif/ppmc_seq.sv ====
`timescale 1ns/1ps
module ppmc_seq
(
	input wire clk_i,
	input wire resetn_i,
	input wire wait_req_i,
	input wire release_i,
	output reg boundary_o,
	output reg wait_active_o
);
reg [1:0] cnt_r;
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		cnt_r <= 2'h0;
		boundary_o <= 1'b0;
		wait_active_o <= 1'b0;
	end
	else
	begin
		cnt_r <= cnt_r + 2'h1;
		boundary_o <= (cnt_r == 2'h3);
		if (release_i)
			wait_active_o <= 1'b0;
		else if (wait_req_i)
			wait_active_o <= 1'b1;
	end
end
endmodule // ppmc_seq

// ==== verif/ppmc_top_test.sv ====
`timescale 1ns/1ps
`include "ppmc_defs.vh"
module ppmc_top_test;
reg clk = 1'b0;
reg rstn = 1'b0;
reg hw = 1'b0;
reg wq = 1'b0;
reg [1:0] ht = 2'h0;
reg [31:0] ha = 32'h0000_0000, hd = 32'h0000_0000, pin = 32'hFFFF_FFFF;
reg [7:0] sa = 8'h00;
wire [31:0] hr, po, oe;
wire [7:0] sd;
wire [3:0] sn;
wire bd, wa, dn, rl, sw, hro, hrs;
integer n_mismatch = 0, n_checks = 0, nrl = 0, nsw = 0;
localparam [31:0] p2 = 32'h0000_0004, z = 32'h0000_0000;
always #2 clk = ~clk;
always @(posedge clk)
begin
	nrl <= nrl + rl;
	nsw <= nsw + sw;
end
ppmc_top ppmc_top_i (.sys_clk_i(clk), .resetn_i(rstn), .haddr_i(ha), .htrans_i(ht),
	.hwrite_i(hw), .hsize_i(3'h2), .hsel_i(1'b1), .hready_i(hro), .hwdata_i(hd),
	.hrdata_o(hr), .hreadyout_o(hro), .hresp_o(hrs), .pin_in_i(pin), .pin_out_o(po),
	.pin_oe_n_o(oe), .boundary_i(bd), .wait_active_i(wa), .boundary_done_o(dn),
	.wait_release_o(rl), .slot_switch_o(sw), .slot_num_o(sn), .scratch_addr_i(sa),
	.scratch_data_o(sd));
ppmc_seq ppmc_seq_i (.clk_i(clk), .resetn_i(rstn), .wait_req_i(wq), .release_i(rl),
	.boundary_o(bd), .wait_active_o(wa));
task report_and_stop;
begin
	if (n_mismatch == 0 && n_checks > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
end
endtask
task chk(input [23:0] nm, input [31:0] s, input [31:0] e);
begin
	n_checks = n_checks + 1;
	if (s !== e)
	begin
		n_mismatch = n_mismatch + 1;
		$display("wrong value %0s exp %h saw %h", nm, e, s);
	end
end
endtask
task wt(input integer n, input dummy);
integer k;
begin
	repeat (n)
	begin
		k = 0;
		@(posedge clk);
		#1;
		while ((dummy ? hro : dn) !== 1'b1)
		begin
			k = k + 1;
			if (k > 20)
			begin
				n_mismatch = n_mismatch + 1;
				report_and_stop;
			end
			@(posedge clk);
			#1;
		end
	end
	if (!dummy)
	begin
		@(posedge clk);
		#1;
	end
end
endtask
task ap(input [31:0] a, input w);
begin
	ha <= a;
	ht <= 2'h2;
	hw <= w;
	wt(1, 1'b1);
	ht <= 2'h0;
end
endtask
task wr(input [31:0] a, input [31:0] d);
begin
	ap(a, 1'b1);
	hd <= d;
	wt(1, 1'b1);
end
endtask
task rd(input [31:0] a, input [31:0] e);
begin
	ap(a, 1'b0);
	wt(1, 1'b1);
	chk("reg", hr, e);
end
endtask
task sc(input [7:0] e);
begin
	sa <= 8'h80;
	repeat (2) @(posedge clk);
	#1;
	chk("scr", {24'h00_0000, sd}, {24'h00_0000, e});
end
endtask
initial
begin
	repeat (20) @(posedge clk);
	rstn <= 1'b1;
	@(posedge clk);
	rd(`PPMC_A_MODE, z);
	chk("oe", oe, 32'hFFFF_FFFF);
	wr(`PPMC_A_IN_EN, 32'h0000_0003);
	wr(`PPMC_A_OUT_EN, p2);
	wr(`PPMC_A_OUT_ACT, p2);
	wr(`PPMC_A_SLOT, 32'h0000_0005);
	wr(`PPMC_A_MODE, 32'h0000_0002);
	wt(2, 1'b0);
	chk("out", po & p2, z);
	pin <= 32'hFFFF_FFFD;
	wq <= 1'b1;
	@(posedge clk);
	wq <= 1'b0;
	wt(3, 1'b0);
	chk("out", po & p2, p2);
	chk("rel", nrl, 1);
	sc(8'h02);
	wr(`PPMC_A_MODE, 32'h0000_0001);
	pin <= 32'hFFFF_FFFF;
	wt(2, 1'b0);
	chk("out", po & p2, p2);
	wr(`PPMC_A_MODE, 32'h0000_0002);
	wt(2, 1'b0);
	chk("out", po & p2, z);
	wr(`PPMC_A_MODE, 32'h0000_0006);
	rd(`PPMC_A_MODE, 32'h0000_0002);
	pin <= 32'hFFFF_FFFE;
	wt(3, 1'b0);
	chk("out", po & p2, z);
	wr(`PPMC_A_OUT_EN, p2);
	wt(2, 1'b0);
	chk("out", po & p2, p2);
	wr(`PPMC_A_MODE, 32'h0000_0006);
	pin <= 32'hFFFF_FFFF;
	wt(3, 1'b0);
	chk("out", po & p2, p2);
	wr(`PPMC_A_OUT_EN, p2);
	pin <= 32'hFFFF_FFFE;
	wr(`PPMC_A_MODE, 32'h0000_0001);
	wq <= 1'b1;
	@(posedge clk);
	wq <= 1'b0;
	wt(1, 1'b0);
	wr(`PPMC_A_MODE, 32'h0000_0003);
	wt(3, 1'b0);
	chk("sw", nsw, 1);
	chk("rel", nrl, 1);
	chk("slt", {28'h000_0000, sn}, 32'h0000_0005);
	rd(`PPMC_A_MODE, 32'h0000_0001);
	wr(`PPMC_A_MODE, 32'h0000_0004);
	wt(3, 1'b0);
	chk("sw", nsw, 2);
	chk("rel", nrl, 2);
	rd(`PPMC_A_MODE, 32'h0000_0002);
	wr(`PPMC_A_MODE, 32'h0000_000A);
	wt(2, 1'b0);
	pin <= 32'hFFFF_FFFF;
	wt(3, 1'b0);
	chk("out", po & p2, p2);
	rd(`PPMC_A_MODE, 32'h0000_000A);
	sc(8'h01);
	wr(`PPMC_A_MODE, z);
	rd(`PPMC_A_IN_EN, z);
	sc(8'h00);
	report_and_stop;
end
endmodule // ppmc_top_test
